// >>> src/rasm_pkg.sv
// Shared constants and types for the receive alarm status monitor.
package rasm_pkg;

    // ==========================================================
    // Register map
    localparam logic [8:0] RX_ALARM_STATUS_OFS = 9'h047;
    localparam int BIT_MF_FAR     = 7;
    localparam int BIT_FR_FAR     = 6;
    localparam int BIT_ALL_ONES   = 4;
    localparam int BIT_AGG_LOSS   = 3;
    localparam int BIT_SIG_LOSS   = 2;
    localparam int BIT_FRAME_LOSS = 1;
    localparam int BIT_SIG_HOLD   = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // ==========================================================
    // Timing
    localparam int SYS_CLK_MHZ       = 250;
    localparam int AGG_LOSS_TIME_US  = 1000;
    localparam int AGG_LOSS_CYC      = AGG_LOSS_TIME_US * SYS_CLK_MHZ;
    localparam int HOLD_EXTRA_MS     = 6;
    localparam int HOLD_EXTRA_CYC    = HOLD_EXTRA_MS * 1000 * SYS_CLK_MHZ;
    localparam int CLK_LOSS_CYC      = 64;

    // ==========================================================
    // Line bit counts
    localparam logic [6:0]  T1_LOS_RUN     = 7'd100;
    localparam logic [6:0]  E1_LOS_RUN     = 7'd32;
    localparam logic [7:0]  T1_LOS_WIN     = 8'd114;
    localparam logic [7:0]  E1_LOS_WIN     = 8'd193;
    localparam logic [7:0]  T1_LOS_ONES    = 8'd15;
    localparam logic [7:0]  E1_LOS_ONES    = 8'd1;
    localparam logic [12:0] T1_AIS_WIN     = 13'd4632;
    localparam logic [12:0] E1_AIS_WIN     = 13'd512;
    localparam logic [2:0]  T1_AIS_LOW_MAX = 3'd4;
    localparam logic [2:0]  E1_AIS_LOW_MAX = 3'd2;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        MODE_T1_SF,
        MODE_T1_JAPAN,
        MODE_T1_DM,
        MODE_T1_ESF,
        MODE_E1_FAS,
        MODE_E1_CAS
    } rasm_mode_t;

    typedef struct packed {
        logic yb2;
        logic yj;
        logic y24;
        logic y0;
        logic yfdl;
        logic y16;
    } rasm_yel_t;

    typedef struct packed {
        logic fas_align_lost;
        logic mfas_align_lost;
        logic cas_align_lost;
        logic frame_loss_rt;
        logic frame_loss_int;
        logic frame_align_changed;
    } rasm_align_t;

    function automatic logic rasm_is_e1(input rasm_mode_t m);
        return (m == MODE_E1_FAS) || (m == MODE_E1_CAS);
    endfunction

endpackage

// >>> src/rasm_top.sv
// Receive alarm detection and the receive alarm status register.
`timescale 1ns/1ns
module rasm_top
#(
    parameter int AGG_LOSS_CYCLES  = rasm_pkg::AGG_LOSS_CYC,
    parameter int HOLD_EXTRA_CYCLES = rasm_pkg::HOLD_EXTRA_CYC
)
(
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_rx_line_clock,
    input  wire logic                 i_rx_data,
    input  wire rasm_pkg::rasm_mode_t i_mode,
    input  wire logic                 i_far_alarm_integration,
    input  wire logic                 i_frame_loss_integration,
    input  wire logic [1:0]           i_out_of_frame_criteria,
    input  wire logic                 i_aggregate_loss_source_sel,
    input  wire logic                 i_forced_hold_on,
    input  wire logic                 i_forced_hold_off,
    input  wire rasm_pkg::rasm_yel_t  i_yel_rt,
    input  wire rasm_pkg::rasm_yel_t  i_yel_int,
    input  wire rasm_pkg::rasm_align_t i_align,
    input  wire logic [8:0]           i_reg_addr,
    input  wire logic                 i_reg_rd,
    input  wire logic                 i_reg_wr,
    input  wire logic [7:0]           i_reg_wdata,
    output logic [7:0]                o_reg_rdata,
    output logic [7:0]                o_receive_alarm_status,
    output logic                      o_rx_alarm_irq_status,
    output logic                      o_signaling_hold
);
    import rasm_pkg::*;

    // ==========================================================
    // Configuration into the line clock domain
    // The line clock may stop, so the line side only ever reads
    // quasi-static levels through a three-stage filter.
    logic [1:0] l_s1_q;
    logic [1:0] l_s2_q;
    logic [1:0] l_s3_q;
    logic [1:0] l_cfg_q;
    logic       l_is_e1;
    logic       l_fas_lost;

    always_ff @(posedge i_rx_line_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            l_s1_q  <= 2'b00;
            l_s2_q  <= 2'b00;
            l_s3_q  <= 2'b00;
            l_cfg_q <= 2'b00;
        end
        else
        begin
            l_s1_q <= {rasm_is_e1(i_mode), i_align.fas_align_lost};
            l_s2_q <= l_s1_q;
            l_s3_q <= l_s2_q;
            for (int i = 0; i < 2; i++)
                if (l_s2_q[i] == l_s3_q[i])
                    l_cfg_q[i] <= l_s3_q[i];
        end
    end

    assign l_is_e1    = l_cfg_q[1];
    assign l_fas_lost = l_cfg_q[0];

    // ==========================================================
    // Loss of signal on the line clock
    logic [6:0] zrun_q;
    logic [6:0] zrun_d;
    logic       los_q;
    logic       win_act_q;
    logic [7:0] win_cnt_q;
    logic [7:0] win_ones_q;
    logic [7:0] ones_d;
    logic       win_bad_q;
    logic       bad_d;
    logic [6:0] run_thr;
    logic [7:0] win_len;
    logic [7:0] min_ones;

    assign run_thr  = l_is_e1 ? E1_LOS_RUN  : T1_LOS_RUN;
    assign win_len  = l_is_e1 ? E1_LOS_WIN  : T1_LOS_WIN;
    assign min_ones = l_is_e1 ? E1_LOS_ONES : T1_LOS_ONES;
    assign zrun_d   = i_rx_data ? 7'd0
                    : (zrun_q == 7'h7f) ? zrun_q : zrun_q + 7'd1;
    assign ones_d   = win_ones_q + {7'd0, i_rx_data};
    assign bad_d    = win_bad_q || (zrun_d >= run_thr);

    always_ff @(posedge i_rx_line_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            zrun_q     <= 7'd0;
            los_q      <= 1'b0;
            win_act_q  <= 1'b0;
            win_cnt_q  <= 8'd0;
            win_ones_q <= 8'd0;
            win_bad_q  <= 1'b0;
        end
        else
        begin
            zrun_q <= zrun_d;
            if (!los_q)
            begin
                win_act_q <= 1'b0;
                if (zrun_d >= run_thr)
                    los_q <= 1'b1;
            end
            else if (!win_act_q)
            begin
                if (i_rx_data)
                begin
                    win_act_q  <= 1'b1;
                    win_cnt_q  <= 8'd1;
                    win_ones_q <= 8'd1;
                    win_bad_q  <= 1'b0;
                end
            end
            else
            begin
                win_cnt_q  <= win_cnt_q + 8'd1;
                win_ones_q <= ones_d;
                win_bad_q  <= bad_d;
                if (win_cnt_q + 8'd1 == win_len)
                begin
                    win_act_q <= 1'b0;
                    if (!bad_d && ones_d >= min_ones)
                        los_q <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // All-ones indication on the line clock
    logic [12:0] ais_cnt_q;
    logic [2:0]  ais_zeros_q;
    logic [2:0]  zeros_d;
    logic        prev_low_q;
    logic        ais_q;
    logic        win_low;
    logic [12:0] ais_len;

    assign ais_len = l_is_e1 ? E1_AIS_WIN : T1_AIS_WIN;
    assign zeros_d = (i_rx_data || ais_zeros_q == 3'h7) ? ais_zeros_q
                   : ais_zeros_q + 3'd1;
    assign win_low = zeros_d <= (l_is_e1 ? E1_AIS_LOW_MAX : T1_AIS_LOW_MAX);

    always_ff @(posedge i_rx_line_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ais_cnt_q   <= 13'd0;
            ais_zeros_q <= 3'd0;
            prev_low_q  <= 1'b0;
            ais_q       <= 1'b0;
        end
        else
        begin
            if (ais_cnt_q + 13'd1 >= ais_len)
            begin
                ais_cnt_q   <= 13'd0;
                ais_zeros_q <= 3'd0;
                prev_low_q  <= win_low;
                if (l_is_e1)
                begin
                    if (win_low && prev_low_q && l_fas_lost)
                        ais_q <= 1'b1;
                    else if (!win_low && !prev_low_q)
                        ais_q <= 1'b0;
                end
                else
                begin
                    if (win_low && l_fas_lost)
                        ais_q <= 1'b1;
                    else if (!win_low)
                        ais_q <= 1'b0;
                end
            end
            else
            begin
                ais_cnt_q   <= ais_cnt_q + 13'd1;
                ais_zeros_q <= zeros_d;
            end
            if (!l_fas_lost)
                ais_q <= 1'b0;
        end
    end

    // ==========================================================
    // Line results into the system clock domain
    logic       l_tgl_q;
    logic [2:0] s_s1_q;
    logic [2:0] s_s2_q;
    logic [2:0] s_s3_q;
    logic [2:0] s_line_q;

    always_ff @(posedge i_rx_line_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            l_tgl_q <= 1'b0;
        else
            l_tgl_q <= !l_tgl_q;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_s1_q   <= 3'b000;
            s_s2_q   <= 3'b000;
            s_s3_q   <= 3'b000;
            s_line_q <= 3'b000;
        end
        else
        begin
            s_s1_q <= {l_tgl_q, ais_q, los_q};
            s_s2_q <= s_s1_q;
            s_s3_q <= s_s2_q;
            for (int i = 0; i < 3; i++)
                if (s_s2_q[i] == s_s3_q[i])
                    s_line_q[i] <= s_s3_q[i];
        end
    end

    // ==========================================================
    // Line clock presence watchdog
    // A toggle that stops changing means the line clock stopped.
    logic        tgl_prev_q;
    logic [15:0] clk_idle_q;
    logic        clk_absent_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tgl_prev_q   <= 1'b0;
            clk_idle_q   <= 16'h0000;
            clk_absent_q <= 1'b0;
        end
        else
        begin
            tgl_prev_q <= s_line_q[2];
            if (s_line_q[2] != tgl_prev_q)
            begin
                clk_idle_q   <= 16'h0000;
                clk_absent_q <= 1'b0;
            end
            else if (clk_idle_q == 16'(CLK_LOSS_CYC - 1))
                clk_absent_q <= 1'b1;
            else
                clk_idle_q <= clk_idle_q + 16'h0001;
        end
    end

    // ==========================================================
    // Aggregate loss
    logic [31:0] los_age_q;
    logic        los_long_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            los_age_q  <= 32'h0000_0000;
            los_long_q <= 1'b0;
        end
        else if (!s_line_q[0])
        begin
            los_age_q  <= 32'h0000_0000;
            los_long_q <= 1'b0;
        end
        else if (los_age_q == 32'(AGG_LOSS_CYCLES - 1))
            los_long_q <= 1'b1;
        else
            los_age_q <= los_age_q + 32'h0000_0001;
    end

    // ==========================================================
    // Far alarms and frame loss selection
    logic      frame_far;
    logic      mf_far;
    logic      frame_loss;
    rasm_yel_t yel;

    always_comb
    begin
        yel = i_far_alarm_integration ? i_yel_int : i_yel_rt;
        // Yellow is read at the last known alignment and is only
        // trustworthy while frame alignment holds.
        mf_far = 1'b0;
        case (i_mode)
            MODE_T1_SF:    frame_far = yel.yb2;
            MODE_T1_JAPAN: frame_far = yel.yj;
            MODE_T1_DM:    frame_far = yel.y24;
            MODE_T1_ESF:
            begin
                frame_far = yel.yb2;
                mf_far    = yel.yfdl;
            end
            MODE_E1_FAS:   frame_far = yel.y0;
            MODE_E1_CAS:
            begin
                frame_far = yel.y0;
                mf_far    = yel.y16;
            end
            default:       frame_far = 1'b0;
        endcase
    end

    always_comb
    begin
        // The framer already applies the chosen out-of-frame rule.
        if (rasm_is_e1(i_mode))
            frame_loss = i_align.fas_align_lost
                       | i_align.mfas_align_lost
                       | i_align.cas_align_lost;
        else if (i_frame_loss_integration)
            frame_loss = i_align.frame_loss_int;
        else
            frame_loss = i_align.frame_loss_rt;
    end

    // ==========================================================
    // Signaling hold
    logic [31:0] hold_cnt_q;
    logic        hold_auto_q;
    logic        hold_q;
    logic        hold_cause;

    assign hold_cause = i_align.frame_align_changed | frame_loss;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hold_cnt_q  <= 32'h0000_0000;
            hold_auto_q <= 1'b0;
        end
        else if (hold_cause)
        begin
            hold_cnt_q  <= 32'(HOLD_EXTRA_CYCLES);
            hold_auto_q <= 1'b1;
        end
        else if (hold_cnt_q != 32'h0000_0000)
            hold_cnt_q <= hold_cnt_q - 32'h0000_0001;
        else
            hold_auto_q <= 1'b0;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            hold_q <= 1'b0;
        else if (i_forced_hold_on)
            hold_q <= 1'b1;
        else if (i_forced_hold_off)
            hold_q <= 1'b0;
        else
            hold_q <= hold_auto_q;
    end

    // Consumers stop buffer writes and freeze outputs on this level.
    assign o_signaling_hold = hold_q;

    // ==========================================================
    // Status register, change flag and read port
    logic [7:0] status_d;
    logic [7:0] status_q;

    always_comb
    begin
        status_d                 = STATUS_RESET;
        status_d[BIT_MF_FAR]     = mf_far;
        status_d[BIT_FR_FAR]     = frame_far;
        status_d[BIT_ALL_ONES]   = s_line_q[1];
        status_d[BIT_AGG_LOSS]   = i_aggregate_loss_source_sel
                                 ? clk_absent_q : los_long_q;
        status_d[BIT_SIG_LOSS]   = s_line_q[0];
        status_d[BIT_FRAME_LOSS] = frame_loss;
        status_d[BIT_SIG_HOLD]   = hold_q;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            status_q              <= STATUS_RESET;
            o_rx_alarm_irq_status <= 1'b0;
        end
        else
        begin
            status_q              <= status_d;
            o_rx_alarm_irq_status <= status_d != status_q;
        end
    end

    assign o_receive_alarm_status = status_q;

    // Reads only sample; writes never reach the status bits.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_reg_rdata <= 8'h00;
        else if (i_reg_rd && i_reg_addr == RX_ALARM_STATUS_OFS)
            o_reg_rdata <= status_q;
        else
            o_reg_rdata <= 8'h00;
    end

    logic unused_ok;
    assign unused_ok = i_reg_wr ^ (^i_reg_wdata) ^ (^i_out_of_frame_criteria);

endmodule // rasm_top

// >>> verif/rasm_line_model.sv
// Line interface model driving the receive line clock and data.
`timescale 1ns/1ns
module rasm_line_model
(
    input  wire logic i_run,
    input  wire logic i_bit,
    output logic      o_clk,
    output logic      o_data
);
    logic last_q;
    initial
    begin
        o_clk  = 1'b0;
        o_data = 1'b1;
        last_q = 1'b1;
        #7;
        forever
        begin
            if (i_run)
            begin
                o_data = i_bit;
                last_q = i_bit;
                #40 o_clk = 1'b1;
                #40 o_clk = 1'b0;
            end
            else
            begin
                // The clock stands still; a stale bit must not look valid.
                o_data = ~last_q;
                #40;
            end
        end
    end
endmodule // rasm_line_model

// >>> verif/rasm_top_properties.sv
// Concurrent checks on the receive alarm status monitor ports.
`timescale 1ns/1ns
module rasm_top_properties
(
    input wire logic                  i_clk_sys,
    input wire logic                  i_rst_n,
    input wire rasm_pkg::rasm_mode_t  i_mode,
    input wire logic                  i_forced_hold_on,
    input wire logic                  i_forced_hold_off,
    input wire rasm_pkg::rasm_align_t i_align,
    input wire logic [8:0]            i_reg_addr,
    input wire logic                  i_reg_rd,
    input wire logic [7:0]            o_reg_rdata,
    input wire logic [7:0]            o_receive_alarm_status,
    input wire logic                  o_rx_alarm_irq_status,
    input wire logic                  o_signaling_hold
);
    import rasm_pkg::*;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    logic       rd_hit;
    logic       e1;
    logic       mf_mode;
    logic [7:0] st;
    assign st      = o_receive_alarm_status;
    assign rd_hit  = i_reg_rd && (i_reg_addr == RX_ALARM_STATUS_OFS);
    assign e1      = (i_mode == MODE_E1_FAS) || (i_mode == MODE_E1_CAS);
    assign mf_mode = (i_mode == MODE_T1_ESF) || (i_mode == MODE_E1_CAS);
    // ====
    // Sequences
    sequence s_status_step;
        st != $past(st);
    endsequence
    sequence s_force_on;
        i_forced_hold_on [*3];
    endsequence
    sequence s_force_off;
        (i_forced_hold_off && !i_forced_hold_on) [*3];
    endsequence
    // ====
    // Assertions
    a_irq_on_change: assert property (s_status_step |->
        o_rx_alarm_irq_status) else $error("irq missing after status change");
    a_irq_quiet_idle: assert property (o_rx_alarm_irq_status |->
        st != $past(st)) else $error("irq without status change");
    a_spare_bit_zero: assert property (!st[5])
        else $error("spare status bit set");
    a_hold_mirrors_bit: assert property (
        st[BIT_SIG_HOLD] == $past(o_signaling_hold))
        else $error("hold output differs from status bit");
    a_read_returns_status: assert property (rd_hit |=>
        o_reg_rdata == $past(st)) else $error("read data differs from status");
    a_read_other_zero: assert property (!rd_hit |=> o_reg_rdata == 8'h00)
        else $error("read data without status read");
    a_mf_far_idle: assert property (!mf_mode |=> !st[BIT_MF_FAR])
        else $error("multiframe far alarm outside its modes");
    a_e1_frame_loss: assert property (e1 |=> st[BIT_FRAME_LOSS] ==
        $past(i_align.fas_align_lost | i_align.mfas_align_lost |
        i_align.cas_align_lost)) else $error("e1 frame loss mismatch");
    a_forced_hold_on: assert property (s_force_on |-> o_signaling_hold)
        else $error("forced hold on not shown");
    a_forced_hold_off: assert property (s_force_off |-> !o_signaling_hold)
        else $error("forced hold off not shown");
endmodule // rasm_top_properties
bind rasm_top rasm_top_properties u_props
(
    .i_clk_sys              (i_clk_sys),
    .i_rst_n                (i_rst_n),
    .i_mode                 (i_mode),
    .i_forced_hold_on       (i_forced_hold_on),
    .i_forced_hold_off      (i_forced_hold_off),
    .i_align                (i_align),
    .i_reg_addr             (i_reg_addr),
    .i_reg_rd               (i_reg_rd),
    .o_reg_rdata            (o_reg_rdata),
    .o_receive_alarm_status (o_receive_alarm_status),
    .o_rx_alarm_irq_status  (o_rx_alarm_irq_status),
    .o_signaling_hold       (o_signaling_hold)
);

// >>> verif/rasm_top_test.sv
// Self-checking testbench for the receive alarm status monitor.
`timescale 1ns/1ns
module rasm_top_test;
    import rasm_pkg::*;
    // Short counts keep the run small; expectations use these values.
    localparam int AGG  = 50;
    localparam int HOLD = 40;
    logic        clk, rst_n, run, lbit, lclk, ldata;
    logic        integ, fli, sel, hon, hoff, rd, wr, irq, hold;
    logic [1:0]  ooc;
    logic [8:0]  addr;
    logic [7:0]  wdata, rdata, status, st;
    rasm_mode_t  mode;
    rasm_yel_t   yr, yi, y;
    rasm_align_t al;
    integer      seed = 32'hf7ad_ce78;
    int          err_total, num_checks, cyc;
    rasm_top #(.AGG_LOSS_CYCLES(AGG), .HOLD_EXTRA_CYCLES(HOLD)) dut_u (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_rx_line_clock(lclk),
        .i_rx_data(ldata), .i_mode(mode), .i_far_alarm_integration(integ),
        .i_frame_loss_integration(fli), .i_out_of_frame_criteria(ooc),
        .i_aggregate_loss_source_sel(sel), .i_forced_hold_on(hon),
        .i_forced_hold_off(hoff), .i_yel_rt(yr), .i_yel_int(yi),
        .i_align(al), .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_receive_alarm_status(status), .o_rx_alarm_irq_status(irq),
        .o_signaling_hold(hold));
    rasm_line_model u_line (.i_run(run), .i_bit(lbit), .o_clk(lclk),
        .o_data(ldata));
    // ====
    // Expectations
    function automatic logic [1:0] exp_far(rasm_mode_t m, rasm_yel_t v);
        case (m)
            MODE_T1_SF:    return {1'b0, v.yb2};
            MODE_T1_JAPAN: return {1'b0, v.yj};
            MODE_T1_DM:    return {1'b0, v.y24};
            MODE_T1_ESF:   return {v.yfdl, v.yb2};
            MODE_E1_FAS:   return {1'b0, v.y0};
            default:       return {v.y16, v.y0};
        endcase
    endfunction
    function automatic logic exp_fl(rasm_mode_t m, logic f, rasm_align_t a);
        if (m == MODE_E1_FAS || m == MODE_E1_CAS)
            return a.fas_align_lost | a.mfas_align_lost | a.cas_align_lost;
        return f ? a.frame_loss_int : a.frame_loss_rt;
    endfunction
    // ====
    // Tasks
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd_reg(input logic [8:0] a, output logic [7:0] v);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        v = rdata;
    endtask
    task automatic send(input logic b, input int n);
        // Change just after a line edge so every counted edge carries b.
        @(posedge lclk);
        lbit = b;
        repeat (n) @(posedge lclk);
        repeat (10) @(negedge clk);
        rd_reg(RX_ALARM_STATUS_OFS, st);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            err_total++;
            complete_run();
        end
    end
    initial
    begin
        {rst_n, lbit, run} = 3'b011;
        {integ, fli, sel, hon, hoff, rd, wr} = 7'h00;
        {ooc, addr, wdata, yr, yi, al} = 37'h00_0000_0000;
        mode = MODE_T1_SF;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rd_reg(RX_ALARM_STATUS_OFS, st);
        chk("reset_status", st, STATUS_RESET);
        // Random far alarm, frame loss and forced hold settings.
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clk);
            mode = rasm_mode_t'(($random(seed) & 32'h7fff_ffff) % 6);
            {integ, fli, hon, hoff, ooc} = 6'($random(seed));
            {yr, yi, al} = 18'($random(seed));
            {wr, addr, wdata} = {1'b1, RX_ALARM_STATUS_OFS, 8'($random(seed))};
            @(negedge clk);
            wr = 1'b0;
            y = integ ? yi : yr;
            rd_reg(RX_ALARM_STATUS_OFS, st);
            chk("far_alarms", 8'(st[7:6]), 8'(exp_far(mode, y)));
            chk("frame_loss", 8'(st[1]), 8'(exp_fl(mode, fli, al)));
            chk("spare_bit", 8'(st[5]), 8'h00);
            if (hon | hoff)
                chk("forced_hold", 8'(st[0]), 8'(hon));
            rd_reg(9'h048, st);
            chk("unmapped_read", st, 8'h00);
        end
        {hon, hoff, al} = {2'b00, 6'h01};
        mode = MODE_T1_SF;
        repeat (5) @(negedge clk);
        al = 6'h00;
        rd_reg(RX_ALARM_STATUS_OFS, st);
        chk("hold_active", 8'(st[0]), 8'h01);
        repeat (30) @(negedge clk);
        rd_reg(RX_ALARM_STATUS_OFS, st);
        chk("hold_tail", 8'(st[0]), 8'h01);
        repeat (3 * HOLD) @(negedge clk);
        rd_reg(RX_ALARM_STATUS_OFS, st);
        chk("hold_end", 8'(st[0]), 8'h00);
        // T1 then E1 signal loss, run lengths at their boundaries.
        send(1'b1, 200);
        send(1'b0, 99);
        chk("t1_los_99", 8'(st[3:2]), 8'h00);
        send(1'b0, 1);
        chk("t1_los_100", 8'(st[3:2]), 8'h01);
        send(1'b0, 10);
        chk("agg_loss_sig", 8'(st[3]), 8'h01);
        send(1'b1, 130);
        chk("t1_los_clear", 8'(st[3:2]), 8'h00);
        mode = MODE_E1_FAS;
        send(1'b1, 250);
        send(1'b0, 31);
        chk("e1_los_31", 8'(st[2]), 8'h00);
        send(1'b0, 1);
        chk("e1_los_32", 8'(st[2]), 8'h01);
        send(1'b1, 200);
        chk("e1_los_clear", 8'(st[2]), 8'h00);
        // All ones with lost alignment, then recovery.
        al = 6'h20;
        send(1'b1, 1600);
        chk("e1_ais_set", 8'(st[4]), 8'h01);
        al = 6'h00;
        send(1'b1, 5);
        chk("e1_ais_clear", 8'(st[4]), 8'h00);
        // Clock-loss source: stop the line clock, then restart it.
        sel = 1'b1;
        send(1'b1, 5);
        run = 1'b0;
        repeat (120) @(negedge clk);
        rd_reg(RX_ALARM_STATUS_OFS, st);
        chk("clock_absent", 8'(st[3]), 8'h01);
        run = 1'b1;
        send(1'b1, 5);
        chk("clock_present", 8'(st[3]), 8'h00);
        complete_run();
    end
endmodule // rasm_top_test
